/* hdl/ring_phy_pkg.sv */
// Package for the ring physical-interface control logic.
// Assumes a 100 MHz reference clock feeds every count below.
package ring_phy_pkg;

  // Reference clock rate used to turn times into cycle counts.
  localparam int REF_CLK_MHZ = 100;

  // Rate window: 1.5 us, a least time, so rounded up.
  localparam int WINDOW_NS  = 1500;
  localparam int WINDOW_CYC = (WINDOW_NS * REF_CLK_MHZ + 999) / 1000;

  // Transition counts that classify one window.
  localparam logic [7:0] FAST_MIN_TRANS = 8'h10;  // 16 or more is 16 Mbps.
  localparam logic [7:0] IDLE_MAX_TRANS = 8'h01;  // One or fewer is no activity.

  // Synchroniser, edge detector and output register eat this many cycles of every time limit.
  localparam int SYNC_LAT = 4;

  // Recovery-loop reset: ready again at most 3 us after the pin rises, latency included.
  localparam int FREQ_ACQUIRE_REQ_NS  = 3000;
  localparam int FREQ_ACQUIRE_REQ_CYC = (FREQ_ACQUIRE_REQ_NS * REF_CLK_MHZ) / 1000 - SYNC_LAT;

  // Watchdog: expires at most 22 ms after the last pin toggle, latency included.
  localparam int WDOG_MS  = 22;
  localparam int WDOG_CYC = WDOG_MS * REF_CLK_MHZ * 1000 - SYNC_LAT;

  // Clock synthesis half periods in reference cycles.
  localparam int RING_REF_HALF = 3;
  localparam int FAST_HALF     = 2;

  // Values after reset.
  localparam logic RST_READY_N = 1'b1;
  localparam logic RST_ERROR_N = 1'b1;
  localparam logic RST_FAULT_N = 1'b1;

  // Idle pin levels loaded into the synchronisers, so that release of reset shows no false edge.
  // Bits from the top: speed, rate source, acquire, fault b, fault a, insert, repeat, loopback.
  localparam logic [7:0] PIN_IDLE = 8'h07;

  // Clock-recovery loop states.
  typedef enum logic {LOOP_LOCKED, LOOP_RESETTING} loop_state_t;

endpackage

/* hdl/ring_phy_ctrl.sv */
// Control logic of a 4/16 Mbps token-ring physical interface: wrap and
// repeat multiplexing, insertion watchdog, wire fault, loop-ready handshake
// and rate-error detection. Assumes pins arrive asynchronously and the
// line clock is an independent clock from the analog recovery front end.
`timescale 1ns/1ps

module ring_phy_ctrl #(
  parameter int WDOG_CYCLES = ring_phy_pkg::WDOG_CYC,
  parameter int WIN_CYCLES  = ring_phy_pkg::WINDOW_CYC,
  parameter int FREQ_ACQUIRE_REQ_CYCLES = ring_phy_pkg::FREQ_ACQUIRE_REQ_CYC
) (
  // Reference clock domain.
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  input  wire logic i_clk_en,
  // Line clock domain.
  input  wire logic i_line_clk,
  // Mode pins.
  input  wire logic i_loopback_n,
  input  wire logic i_repeat_select_n,
  input  wire logic i_speed_select,
  // Transmit from processor and line.
  input  wire logic i_tx_in_pair_p,
  input  wire logic i_tx_in_pair_n,
  output logic      o_line_tx_pair_p,
  output logic      o_line_tx_pair_n,
  // Receive from line and to processor.
  input  wire logic i_line_rx_pair,
  output logic      o_recovered_data,
  output logic      o_recovered_clock,
  // Synthesized clocks.
  output logic      o_ring_ref_clock,
  output logic      o_fixed_fast_clock,
  // Insertion and wire fault.
  input  wire logic i_insert_request_n,
  input  wire logic i_load_fault_a,
  input  wire logic i_load_fault_b,
  output logic      o_phantom_out_a,
  output logic      o_phantom_out_b,
  output logic      o_wire_fault_n,
  // Recovery loop and rate.
  input  wire logic i_freq_acquire_req,
  output logic      o_loop_reset,
  output logic      o_loop_ready_n,
  output logic      o_rate_error_n
);

  // Counts that the logic cannot serve are refused at elaboration.
  if (WDOG_CYCLES < 2 || WIN_CYCLES < 2 || WIN_CYCLES > 255 || FREQ_ACQUIRE_REQ_CYCLES < 1 || FREQ_ACQUIRE_REQ_CYCLES > 65535) begin : g_bad
    $error("ring_phy_ctrl: unsupported count parameter");
  end

  // Two-stage synchronisers for the eight pins gathered in pin_raw; of the transmit pair only i_tx_in_pair_p enters them, in loopback, as the rate source.
  localparam int NS = 8;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  logic [NS-1:0] pin_prev_q;
  logic          rate_src;

  // In loopback the detector watches the transmit pair instead.
  assign rate_src = i_loopback_n ? i_line_rx_pair : i_tx_in_pair_p;
  assign pin_raw  = {i_speed_select, rate_src, i_freq_acquire_req, i_load_fault_b, i_load_fault_a,
                     i_insert_request_n, i_repeat_select_n, i_loopback_n};

  // Synchroniser registers; only the second stage and its delayed copy are read.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      sync1_q    <= ring_phy_pkg::PIN_IDLE;
      sync2_q    <= ring_phy_pkg::PIN_IDLE;
      pin_prev_q <= ring_phy_pkg::PIN_IDLE;
    end else if (i_clk_en) begin
      sync1_q    <= pin_raw;
      sync2_q    <= sync1_q;
      pin_prev_q <= sync2_q;
    end
  end

  logic loop_s;
  logic rep_s;
  logic insert_request_n_s;
  logic fault_s;
  logic freq_acquire_req_rise;
  logic insert_request_n_fall;
  logic insert_request_n_edge;
  logic src_edge;
  logic speed_s;
  assign loop_s    = ~sync2_q[0];
  assign rep_s     = ~sync2_q[1];
  assign insert_request_n_s    = sync2_q[2];
  assign fault_s   = sync2_q[3] | sync2_q[4];
  assign freq_acquire_req_rise = sync2_q[5] & ~pin_prev_q[5];
  assign insert_request_n_fall = ~sync2_q[2] & pin_prev_q[2];
  assign insert_request_n_edge = sync2_q[2] ^ pin_prev_q[2];
  assign src_edge  = sync2_q[6] ^ pin_prev_q[6];
  assign speed_s   = sync2_q[7];

  // Mode selection; loopback takes priority over repeat.
  logic mode_loop_q;
  logic mode_loop_d;
  logic mode_rep_q;
  logic mode_rep_d;

  always_comb begin
    mode_loop_d = loop_s;
    mode_rep_d  = rep_s & ~loop_s;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      mode_loop_q <= 1'b0;
      mode_rep_q  <= 1'b0;
    end else if (i_clk_en) begin
      mode_loop_q <= mode_loop_d;
      mode_rep_q  <= mode_rep_d;
    end
  end

  // Line clock domain: reset synchroniser, receive retiming, recovered clock.
  // The receive source is chosen ahead of the synchroniser.
  logic line_src;
  logic lrst1_q;
  logic lrst2_q;
  logic rx1_q;
  logic rx2_q;
  logic rclk_q;
  logic rclk_d;
  logic rdata_q;
  logic rdata_d;
  assign line_src = i_loopback_n ? i_line_rx_pair : i_tx_in_pair_p;

  always_ff @(posedge i_line_clk) begin
    lrst1_q <= i_rstn;
    lrst2_q <= lrst1_q;
  end

  // Data moves only as the recovered clock falls, so it is steady at the rise.
  always_comb begin
    rclk_d  = ~rclk_q;
    rdata_d = rclk_q ? rx2_q : rdata_q;
  end

  always_ff @(posedge i_line_clk) begin
    if (!lrst2_q) begin
      rx1_q   <= 1'b0;
      rx2_q   <= 1'b0;
      rclk_q  <= 1'b0;
      rdata_q <= 1'b0;
    end else begin
      rx1_q   <= line_src;
      rx2_q   <= rx1_q;
      rclk_q  <= rclk_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_recovered_data  = rdata_q;
  assign o_recovered_clock = rclk_q;

  // The transmit path is deliberately combinational: retiming would add jitter.
  always_comb begin
    if (mode_loop_q) begin
      o_line_tx_pair_p = 1'b0;
      o_line_tx_pair_n = 1'b0;
    end else if (mode_rep_q) begin
      o_line_tx_pair_p = rdata_q;
      o_line_tx_pair_n = ~rdata_q;
    end else begin
      o_line_tx_pair_p = i_tx_in_pair_p;
      o_line_tx_pair_n = i_tx_in_pair_n;
    end
  end

  // Clock synthesis by two toggle dividers.
  localparam int CLK_HALF [2] = '{ring_phy_pkg::RING_REF_HALF, ring_phy_pkg::FAST_HALF};
  logic [1:0] syn_clk;

  // Each divider owns its register; only the gathered copy is shared.
  for (genvar g = 0; g < 2; g++) begin : g_div
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       clk_q;
    logic       clk_d;
    always_comb begin
      cnt_d = cnt_q + 4'h1;
      clk_d = clk_q;
      if (cnt_q == 4'(CLK_HALF[g] - 1)) begin
        cnt_d = 4'h0;
        clk_d = ~clk_q;
      end
    end
    always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
        cnt_q <= 4'h0;
        clk_q <= 1'b0;
      end else if (i_clk_en) begin
        cnt_q <= cnt_d;
        clk_q <= clk_d;
      end
    end
    assign syn_clk[g] = clk_q;
  end

  assign o_ring_ref_clock   = syn_clk[0];
  assign o_fixed_fast_clock = syn_clk[1];

  // Insertion watchdog, phantom drive and wire fault.
  logic [31:0] wd_cnt_q;
  logic [31:0] wd_cnt_d;
  logic        expired_q;
  logic        expired_d;
  logic        phantom_d;
  logic        phantom_q;
  logic        wfault_n_d;
  logic        wfault_n_q;

  always_comb begin
    wd_cnt_d  = wd_cnt_q;
    expired_d = expired_q;
    if (insert_request_n_edge) begin
      wd_cnt_d = '0;
    end else if (wd_cnt_q != 32'(WDOG_CYCLES - 1)) begin
      wd_cnt_d = wd_cnt_q + 32'h1;
    end else begin
      expired_d = 1'b1;
    end
    if (insert_request_n_fall) begin
      expired_d = 1'b0;
    end
    phantom_d  = ~insert_request_n_s & ~expired_d;
    wfault_n_d = ~(phantom_d & fault_s);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      wd_cnt_q   <= '0;
      expired_q  <= 1'b0;
      phantom_q  <= 1'b0;
      wfault_n_q <= ring_phy_pkg::RST_FAULT_N;
    end else if (i_clk_en) begin
      wd_cnt_q   <= wd_cnt_d;
      expired_q  <= expired_d;
      phantom_q  <= phantom_d;
      wfault_n_q <= wfault_n_d;
    end
  end

  assign o_phantom_out_a = phantom_q;
  assign o_phantom_out_b = phantom_q;
  assign o_wire_fault_n  = wfault_n_q;

  // Rate window: count transitions, classify at the end of each window.
  logic [7:0] win_cnt_q;
  logic [7:0] win_cnt_d;
  logic [7:0] tr_cnt_q;
  logic [7:0] tr_cnt_d;
  logic       win_end;
  logic       active_q;
  logic       active_d;
  logic       rate_err_n_q;
  logic       rate_err_n_d;
  assign win_end = (win_cnt_q == 8'(WIN_CYCLES - 1));

  always_comb begin
    win_cnt_d    = win_end ? 8'h00 : win_cnt_q + 8'h01;
    tr_cnt_d     = (tr_cnt_q == 8'hff) ? tr_cnt_q : tr_cnt_q + {7'h00, src_edge};
    active_d     = active_q;
    rate_err_n_d = rate_err_n_q;
    if (win_end) begin
      tr_cnt_d = {7'h00, src_edge};  // An edge on the closing cycle belongs to the next window.
      active_d = (tr_cnt_q > ring_phy_pkg::IDLE_MAX_TRANS);
      if (!active_d) begin
        rate_err_n_d = 1'b1;
      end else if (speed_s) begin
        rate_err_n_d = (tr_cnt_q < ring_phy_pkg::FAST_MIN_TRANS);
      end else begin
        rate_err_n_d = (tr_cnt_q >= ring_phy_pkg::FAST_MIN_TRANS);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      win_cnt_q    <= 8'h00;
      tr_cnt_q     <= 8'h00;
      active_q     <= 1'b0;
      rate_err_n_q <= ring_phy_pkg::RST_ERROR_N;
    end else if (i_clk_en) begin
      win_cnt_q    <= win_cnt_d;
      tr_cnt_q     <= tr_cnt_d;
      active_q     <= active_d;
      rate_err_n_q <= rate_err_n_d;
    end
  end

  assign o_rate_error_n = rate_err_n_q;

  // Recovery-loop reset handshake and ready output.
  ring_phy_pkg::loop_state_t st_q;
  ring_phy_pkg::loop_state_t st_d;
  logic [15:0] fr_cnt_q;
  logic [15:0] fr_cnt_d;
  logic        ready_n_q;
  logic        ready_n_d;
  logic        lreset_q;
  logic        lreset_d;

  always_comb begin
    st_d     = st_q;
    fr_cnt_d = fr_cnt_q;
    unique case (st_q)
      ring_phy_pkg::LOOP_LOCKED: begin
        if (freq_acquire_req_rise) begin
          st_d     = ring_phy_pkg::LOOP_RESETTING;
          fr_cnt_d = 16'h0000;
        end
      end
      ring_phy_pkg::LOOP_RESETTING: begin
        fr_cnt_d = fr_cnt_q + 16'h0001;
        if (fr_cnt_q == 16'(FREQ_ACQUIRE_REQ_CYCLES - 1)) begin
          st_d = ring_phy_pkg::LOOP_LOCKED;
        end
      end
    endcase
    lreset_d  = (st_d == ring_phy_pkg::LOOP_RESETTING);
    ready_n_d = lreset_d | ~active_d;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_q      <= ring_phy_pkg::LOOP_LOCKED;
      fr_cnt_q  <= 16'h0000;
      lreset_q  <= 1'b0;
      ready_n_q <= ring_phy_pkg::RST_READY_N;
    end else if (i_clk_en) begin
      st_q      <= st_d;
      fr_cnt_q  <= fr_cnt_d;
      lreset_q  <= lreset_d;
      ready_n_q <= ready_n_d;
    end
  end

  assign o_loop_reset   = lreset_q;
  assign o_loop_ready_n = ready_n_q;

  // Checks on the reference domain.
  sequence s_freq_acquire_req_start;
    i_clk_en && st_q == ring_phy_pkg::LOOP_LOCKED && freq_acquire_req_rise;
  endsequence

  property p_loop_tx_low;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      mode_loop_q |-> !o_line_tx_pair_p && !o_line_tx_pair_n;
  endproperty
  a_loop_tx_low: assert property (p_loop_tx_low) else $error("line outputs not low in loopback");

  property p_repeat_gated;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      mode_rep_q |-> !mode_loop_q && o_line_tx_pair_p == rdata_q;
  endproperty
  a_repeat_gated: assert property (p_repeat_gated) else $error("repeat active with loopback");

  property p_phantom_pair;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_phantom_out_a == o_phantom_out_b && (o_phantom_out_a -> !expired_q);
  endproperty
  a_phantom_pair: assert property (p_phantom_pair) else $error("phantom lines disagree");

  property p_fault_idle;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !o_phantom_out_a |-> o_wire_fault_n;
  endproperty
  a_fault_idle: assert property (p_fault_idle) else $error("wire fault low without phantom");

  property p_wdog_expire;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk_en && wd_cnt_q == 32'(WDOG_CYCLES - 1) && !insert_request_n_edge |=> expired_q && !o_phantom_out_a;
  endproperty
  a_wdog_expire: assert property (p_wdog_expire) else $error("watchdog did not drop phantom");

  property p_expired_hold;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      expired_q && !insert_request_n_fall |=> expired_q;
  endproperty
  a_expired_hold: assert property (p_expired_hold) else $error("phantom re-enabled without fall");

  property p_freq_acquire_req_ready;
    @(posedge i_ref_clk) disable iff (!i_rstn || !i_clk_en)
      s_freq_acquire_req_start |=> o_loop_ready_n && o_loop_reset ##[1:400] !o_loop_reset;
  endproperty
  a_freq_acquire_req_ready: assert property (p_freq_acquire_req_ready) else $error("loop reset handshake wrong");

  property p_idle_class;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk_en && win_end && tr_cnt_q <= ring_phy_pkg::IDLE_MAX_TRANS |=> o_rate_error_n && o_loop_ready_n;
  endproperty
  a_idle_class: assert property (p_idle_class) else $error("idle window flagged");

  property p_rate_err;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk_en && win_end && speed_s && tr_cnt_q >= ring_phy_pkg::FAST_MIN_TRANS |=> !o_rate_error_n;
  endproperty
  a_rate_err: assert property (p_rate_err) else $error("fast data at 4 Mbps not flagged");

  // Check on the line domain.
  property p_data_sync;
    @(posedge i_line_clk) disable iff (!lrst2_q)
      $changed(rdata_q) |-> !rclk_q;
  endproperty
  a_data_sync: assert property (p_data_sync) else $error("data moved at recovered clock rise");

endmodule // ring_phy_ctrl

/* sim/ring_proc_model.sv */
// Behavioural model of the protocol processor that faces the ring interface.
// Assumes the bench changes the model's controls just after a falling reference edge.
`timescale 1ns/1ps

module ring_proc_model (
  // Controls from the bench.
  input  wire logic i_ref_clk,
  input  wire logic i_tx_run,
  input  wire logic i_tx_level,
  input  wire logic i_keep_alive,
  input  wire logic i_insert_level,
  // Receive side of the interface.
  input  wire logic i_rx_data,
  input  wire logic i_rx_clock,
  // Drive towards the interface, and the received sample back to the bench.
  output logic      o_tx_p,
  output logic      o_tx_n,
  output logic      o_insert_request_n,
  output logic      o_rx_sample
);
  int tx_cnt = 0;
  int ka_cnt = 0;

  // Every driven line has a defined level from time zero.
  initial begin
    o_tx_p = 1'b0;
    o_insert_request_n = 1'b1;
    o_rx_sample = 1'b0;
  end

  // Drive changes only after a falling edge, so the device never sees a race.
  always @(negedge i_ref_clk) begin
    tx_cnt <= tx_cnt + 1;
    ka_cnt <= (ka_cnt == 119) ? 0 : ka_cnt + 1;
    if (!i_tx_run) begin
      o_tx_p <= i_tx_level;
    end else if (tx_cnt % 4 == 0) begin
      o_tx_p <= ~o_tx_p;
    end
    // A short high pulse every 120 cycles keeps the watchdog well inside its span.
    o_insert_request_n <= i_keep_alive ? (ka_cnt < 2) : i_insert_level;
  end

  // The transmit pair is always complementary.
  assign o_tx_n = ~o_tx_p;

  // Received data is taken on the rising edge of the recovered clock.
  always @(posedge i_rx_clock) begin
    o_rx_sample <= i_rx_data;
  end
endmodule // ring_proc_model

/* sim/tb.sv */
// Self-checking bench for the ring interface control logic.
// Assumes the processor model beside it and a shortened watchdog span.
`timescale 1ns/1ps

module tb;
  localparam int WD = 200;
  logic i_ref_clk = 1'b0;
  logic i_line_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic loop_n = 1'b1, repeat_select_n_n = 1'b1, speed = 1'b0, rx = 1'b0;
  logic fault_a = 1'b0, fault_b = 1'b0, acq = 1'b0;
  logic tx_run = 1'b0, tx_lvl = 1'b0, keep = 1'b0, ins_lvl = 1'b1;
  logic tx_p, tx_n, ins_n, rx_smp, ltx_p, ltx_n, rdata, rclk;
  logic refc, fastc, ph_a, ph_b, wf_n, lrst, rdy_n, err_n;
  int   errors = 0, checked = 0, rx_half = 0, rx_cnt = 0, n1 = 0, n2 = 0, drops, w;
  int   hv[5] = '{9, 9, 10, 10, 0};
  logic sv[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic ev[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic rv[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  // Reference clock at 100 MHz.
  always #5 i_ref_clk = ~i_ref_clk;

  // Line clock of 64 ns, offset so its edges drift against the reference.
  initial begin
    #28;
    forever begin
      i_line_clk = ~i_line_clk;
      #32;
    end
  end

  // Line receive pattern: a toggle every rx_half cycles, or a steady level when zero.
  always @(negedge i_ref_clk) begin
    rx_cnt <= (rx_half != 0 && rx_cnt < rx_half - 1) ? rx_cnt + 1 : 0;
    if (rx_half != 0 && rx_cnt == rx_half - 1) begin
      rx <= ~rx;
    end
  end

  // Edge counters for the synthesized clocks.
  always @(posedge refc) n1++;
  always @(posedge fastc) n2++;

  ring_phy_ctrl #(.WDOG_CYCLES(WD)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_clk_en(1'b1), .i_line_clk(i_line_clk),
    .i_loopback_n(loop_n), .i_repeat_select_n(repeat_select_n_n), .i_speed_select(speed),
    .i_tx_in_pair_p(tx_p), .i_tx_in_pair_n(tx_n), .o_line_tx_pair_p(ltx_p), .o_line_tx_pair_n(ltx_n),
    .i_line_rx_pair(rx), .o_recovered_data(rdata), .o_recovered_clock(rclk),
    .o_ring_ref_clock(refc), .o_fixed_fast_clock(fastc),
    .i_insert_request_n(ins_n), .i_load_fault_a(fault_a), .i_load_fault_b(fault_b),
    .o_phantom_out_a(ph_a), .o_phantom_out_b(ph_b), .o_wire_fault_n(wf_n),
    .i_freq_acquire_req(acq), .o_loop_reset(lrst), .o_loop_ready_n(rdy_n), .o_rate_error_n(err_n)
  );

  ring_proc_model proc_u (
    .i_ref_clk(i_ref_clk), .i_tx_run(tx_run), .i_tx_level(tx_lvl), .i_keep_alive(keep),
    .i_insert_level(ins_lvl), .i_rx_data(rdata), .i_rx_clock(rclk),
    .o_tx_p(tx_p), .o_tx_n(tx_n), .o_insert_request_n(ins_n), .o_rx_sample(rx_smp)
  );

  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tdone(input string t);
    $display("test %s complete", t);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence; reset covers sixteen reference and three line edges.
  initial begin
    cyc(16);
    chk("phantom_a", 8'h00, ph_a);
    chk("wire_fault_n", 8'h01, wf_n);
    chk("ready_n", 8'h01, rdy_n);
    chk("rate_error_n", 8'h01, err_n);
    i_rstn = 1'b1;
    cyc(4);
    tdone("reset");
    for (int v = 0; v < 2; v++) begin
      tx_lvl = v[0];
      cyc(2);
      chk("line_tx_p", v[0], ltx_p);
      chk("line_tx_n", !v[0], ltx_n);
    end
    n1 = 0;
    n2 = 0;
    cyc(60);
    chk("ring_ref_edges", 8'h0a, 8'(n1));
    chk("fast_clock_edges", 8'h0f, 8'(n2));
    tdone("normal");
    // Window boundary cases: 16 or 17 versus exactly 15 transitions, then idle.
    for (int k = 0; k < 5; k++) begin
      rx_half = hv[k];
      speed = sv[k];
      cyc(310);
      chk("rate_error_n", ev[k], err_n);
      chk("ready_n", rv[k], rdy_n);
    end
    tdone("rate");
    rx = 1'b1;
    loop_n = 1'b0;
    tx_run = 1'b1;
    speed = 1'b1;
    cyc(310);
    chk("line_tx_p", 8'h00, ltx_p);
    chk("line_tx_n", 8'h00, ltx_n);
    chk("rate_error_n", 8'h00, err_n);
    repeat_select_n_n = 1'b0;
    cyc(6);
    chk("line_tx_p", 8'h00, ltx_p);
    tx_run = 1'b0;
    for (int v = 0; v < 2; v++) begin
      tx_lvl = v[0];
      cyc(60);
      chk("rx_sample", v[0], rx_smp);
    end
    tdone("loopback");
    loop_n = 1'b1;
    for (int v = 0; v < 2; v++) begin
      rx = v[0];
      tx_lvl = ~v[0];
      cyc(60);
      chk("line_tx_p", v[0], ltx_p);
      chk("line_tx_n", !v[0], ltx_n);
      chk("rx_sample", v[0], rx_smp);
    end
    repeat_select_n_n = 1'b1;
    tdone("repeat");
    rx_half = 9;
    speed = 1'b0;
    cyc(310);
    chk("ready_n", 8'h00, rdy_n);
    acq = 1'b1;
    cyc(5);
    chk("loop_reset", 8'h01, lrst);
    chk("ready_n", 8'h01, rdy_n);
    w = 5;
    while (rdy_n !== 1'b0 && w < 400) begin
      cyc(1);
      w++;
    end
    chk("ready_within_3us", 8'h01, w <= 300);
    acq = 1'b0;
    tdone("acquire");
    ins_lvl = 1'b0;
    cyc(6);
    chk("phantom_a", 8'h01, ph_a);
    chk("phantom_b", 8'h01, ph_b);
    fault_a = 1'b1;
    cyc(5);
    chk("wire_fault_n", 8'h00, wf_n);
    fault_a = 1'b0;
    fault_b = 1'b1;
    cyc(5);
    chk("wire_fault_n", 8'h00, wf_n);
    cyc(WD + 10);
    chk("phantom_a", 8'h00, ph_a);
    chk("wire_fault_n", 8'h01, wf_n);
    cyc(50);
    chk("phantom_b", 8'h00, ph_b);
    fault_b = 1'b0;
    ins_lvl = 1'b1;
    cyc(5);
    ins_lvl = 1'b0;
    cyc(6);
    chk("phantom_a", 8'h01, ph_a);
    // Keep-alive pulses drop the drive briefly; an expiry would drop it for hundreds of cycles.
    keep = 1'b1;
    drops = 0;
    repeat (4 * WD) begin
      cyc(1);
      drops += (ph_a !== 1'b1);
    end
    chk("keep_alive_held", 8'h01, drops < 60);
    keep = 1'b0;
    tdone("watchdog");
    end_sim();
  end

  // A hang is cut short well beyond the expected run of about 3900 cycles.
  initial begin
    #200000;
    errors++;
    end_sim();
  end
endmodule // tb
